/* pkg/irq_ctrl_pkg.sv */
package irq_ctrl_pkg;
    localparam logic [4:0] TEST_RSVD_ADDR = 5'h1c;
    localparam logic [4:0] SRC_FLAGS_ADDR = 5'h1d;
    localparam logic [4:0] EN_MASK_ADDR = 5'h1e;
    localparam logic [4:0] SPECIAL_ADDR = 5'h1f;
    localparam logic [7:0] MASK_RESET = 8'h00;
    localparam logic [7:0] FLAGS_RESET = 8'h00;
    localparam int FLAG_ENERGY = 7;
    localparam int FLAG_AN_DONE = 6;
    localparam int FLAG_RFAULT = 5;
    localparam int FLAG_LINK_DOWN = 4;
    localparam int FLAG_LP_ACK = 3;
    localparam int FLAG_PD_FAULT = 2;
    localparam int FLAG_PAGE_RX = 1;
    localparam int SP_AUTODONE = 12;
    localparam int SP_GPO_LSB = 7;
    localparam int SP_CODER_ON = 6;
    localparam int SP_SPEED_LSB = 2;
    localparam int SP_SCRAMBLE_OFF = 0;
    localparam logic [2:0] GPO_RESET = 3'h0;
    localparam logic CODER_ON_RESET = 1'b1;
    localparam logic SCRAMBLE_OFF_RESET = 1'b0;
    localparam logic [2:0] SPEED_RESET = 3'h0;
    localparam logic [2:0] SPEED_10_HALF = 3'h1;
    localparam logic [2:0] SPEED_10_FULL = 3'h5;
    localparam logic [2:0] SPEED_100_HALF = 3'h2;
    localparam logic [2:0] SPEED_100_FULL = 3'h6;
endpackage

/* pkg/flag_bus_if.sv */
`timescale 1ns/10ps
`default_nettype none
interface flag_bus_if;
    logic [7:0] event_pulse;
    logic clear_all;
    logic [7:0] flags;
    modport owner (input event_pulse, input clear_all, output flags);
    modport user (output event_pulse, output clear_all, input flags);
endinterface
`default_nettype wire

/* logic/sticky_flags.sv */
`timescale 1ns/10ps
`default_nettype none
module sticky_flags
(
    input wire logic clk_in,
    input wire logic sys_rst_in,
    flag_bus_if.owner fb
);
    logic [7:0] flags_reg;

    // set wins over a read-clear in the same cycle
    always_ff @(posedge clk_in)
    begin
        if (sys_rst_in)
        begin
            flags_reg <= irq_ctrl_pkg::FLAGS_RESET;
        end
        else if (fb.clear_all)
        begin
            flags_reg <= fb.event_pulse & 8'hfe; // see R02
        end
        else
        begin
            flags_reg <= flags_reg | (fb.event_pulse & 8'hfe); // see R09
        end
    end

    assign fb.flags = flags_reg;

    chk_flag_holds_high: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        flags_reg[4] && !fb.clear_all |=> flags_reg[4]) // see R09
        else $error("link down flag dropped without a read");
endmodule
`default_nettype wire

/* logic/phy_mgmt_irq_and_special_ctrl.sv */
// Contract
// R01: interrupt output low when any latched flag has its enable bit set.
// R02: reading source flags returns them and clears them, releasing interrupt.
// R03: mask bit set lets same-numbered source pull interrupt low.
// R04: masking gates only the output; flags still latch.
// R05: mask resets to zero, interrupt silent until enabled.
// R06: interrupt output is combinational, may change any time.
// R07: flag 7 energy, flag 6 autoneg done, flag 5 remote fault.
// R08: flag 3 partner ack, flag 2 parallel detect fault, flag 1 page received.
// R09: flag 4 sets on link drop and stays until read.
// R10: host writes zero to mask bits 15:8; they read zero.
// R11: host never writes testability register 28; ignores its read value.
// R12: special bit 12 reads one once autoneg finished.
// R13: special bits 9:7 drive three general purpose outputs, reset zero.
// R14: special bit 6 resets one enabling block coder; zero bypasses it.
// R15: bits 4:2 report resolved speed and duplex code, reset 000; the code shows resolved_speed_code_in directly, with no reset value.
// R16: special bit 0 set turns scrambling off; default clear.
// R17: energy wake raises interrupt when energy source is enabled.
// R18: registers reset only by hardware or software reset, kept in power-down.
// R19: interrupt is inverted OR over bits 7:1 of flag AND enable.
`timescale 1ns/10ps
`default_nettype none
module phy_mgmt_irq_and_special_ctrl
(
    input wire logic clk_in,
    input wire logic sys_rst_in,
    input wire logic soft_rst_in,
    input wire logic [4:0] reg_addr_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    input wire logic [15:0] reg_wdata_in,
    output logic [15:0] reg_rdata_out,
    input wire logic line_energy_present_in,
    input wire logic autoneg_complete_in,
    input wire logic remote_fault_in,
    input wire logic link_status_in,
    input wire logic partner_ack_in,
    input wire logic parallel_detect_fault_in,
    input wire logic page_received_in,
    input wire logic autoneg_done_in,
    input wire logic [2:0] resolved_speed_code_in,
    output logic irq_out_low,
    output logic [2:0] general_outputs_out,
    output logic block_coder_on_out,
    output logic scramble_off_out
);
    logic rst;
    logic [7:0] mask_reg;
    logic [2:0] gpo_reg;
    logic coder_on_reg;
    logic scramble_off_reg;
    logic [15:0] rdata_reg;
    logic [15:0] rdata_next;
    logic energy_d_reg;
    logic link_d_reg;
    logic [7:0] events;
    logic [7:0] flags;
    logic rd_flags;
    logic [15:0] special_view;

    flag_bus_if fb ();

    // power-down does not reach here; only hw and sw reset clear state
    assign rst = sys_rst_in | soft_rst_in; // see R18

    always_ff @(posedge clk_in)
    begin
        if (rst)
        begin
            energy_d_reg <= 1'b0;
            link_d_reg <= 1'b0;
        end
        else
        begin
            energy_d_reg <= line_energy_present_in;
            link_d_reg <= link_status_in;
        end
    end

    always_comb
    begin
        events = 8'h00;
        events[irq_ctrl_pkg::FLAG_ENERGY] = line_energy_present_in & ~energy_d_reg; // see R07
        events[irq_ctrl_pkg::FLAG_AN_DONE] = autoneg_complete_in; // see R07
        events[irq_ctrl_pkg::FLAG_RFAULT] = remote_fault_in; // see R07
        events[irq_ctrl_pkg::FLAG_LINK_DOWN] = link_d_reg & ~link_status_in; // see R09
        events[irq_ctrl_pkg::FLAG_LP_ACK] = partner_ack_in; // see R08
        events[irq_ctrl_pkg::FLAG_PD_FAULT] = parallel_detect_fault_in; // see R08
        events[irq_ctrl_pkg::FLAG_PAGE_RX] = page_received_in; // see R08
    end

    assign rd_flags = reg_rd_in && (reg_addr_in == irq_ctrl_pkg::SRC_FLAGS_ADDR);
    // flags latch regardless of the mask
    assign fb.event_pulse = events; // see R04
    assign fb.clear_all = rd_flags; // see R02
    assign flags = fb.flags;

    sticky_flags u_flags
    (
        .clk_in(clk_in),
        .sys_rst_in(rst),
        .fb(fb)
    );

    always_ff @(posedge clk_in)
    begin
        if (rst)
        begin
            mask_reg <= irq_ctrl_pkg::MASK_RESET; // see R05
        end
        else if (reg_wr_in && reg_addr_in == irq_ctrl_pkg::EN_MASK_ADDR)
        begin
            mask_reg <= reg_wdata_in[7:0]; // see R10
        end
    end

    always_ff @(posedge clk_in)
    begin
        if (rst)
        begin
            gpo_reg <= irq_ctrl_pkg::GPO_RESET;
            coder_on_reg <= irq_ctrl_pkg::CODER_ON_RESET;
            scramble_off_reg <= irq_ctrl_pkg::SCRAMBLE_OFF_RESET;
        end
        else if (reg_wr_in && reg_addr_in == irq_ctrl_pkg::SPECIAL_ADDR)
        begin
            gpo_reg <= reg_wdata_in[irq_ctrl_pkg::SP_GPO_LSB +: 3]; // see R13
            coder_on_reg <= reg_wdata_in[irq_ctrl_pkg::SP_CODER_ON]; // see R14
            scramble_off_reg <= reg_wdata_in[irq_ctrl_pkg::SP_SCRAMBLE_OFF]; // see R16
        end
    end

    always_comb
    begin
        special_view = 16'h0000;
        special_view[irq_ctrl_pkg::SP_AUTODONE] = autoneg_done_in; // see R12
        special_view[irq_ctrl_pkg::SP_GPO_LSB +: 3] = gpo_reg;
        special_view[irq_ctrl_pkg::SP_CODER_ON] = coder_on_reg;
        special_view[irq_ctrl_pkg::SP_SPEED_LSB +: 3] = resolved_speed_code_in; // see R15
        special_view[irq_ctrl_pkg::SP_SCRAMBLE_OFF] = scramble_off_reg;
    end

    // the flag read returns the latched flags only; an event arriving
    // in the read cycle survives the clear and shows on the next read
    always_comb
    begin
        if (reg_addr_in == irq_ctrl_pkg::SRC_FLAGS_ADDR)
        begin
            rdata_next = {8'h00, flags}; // see R02
        end
        else if (reg_addr_in == irq_ctrl_pkg::EN_MASK_ADDR)
        begin
            rdata_next = {8'h00, mask_reg}; // see R10
        end
        else if (reg_addr_in == irq_ctrl_pkg::SPECIAL_ADDR)
        begin
            rdata_next = special_view;
        end
        else
        begin
            // testability block and unknown addresses read zero
            rdata_next = 16'h0000; // see R11
        end
    end

    always_ff @(posedge clk_in)
    begin
        if (rst)
        begin
            rdata_reg <= 16'h0000;
        end
        else if (reg_rd_in)
        begin
            rdata_reg <= rdata_next;
        end
    end

    // no register stage: output follows flags and mask within the cycle
    assign irq_out_low = ~|(flags[7:1] & mask_reg[7:1]); // see R01 R03 R06 R17 R19

    assign reg_rdata_out = rdata_reg;
    assign general_outputs_out = gpo_reg;
    assign block_coder_on_out = coder_on_reg;
    assign scramble_off_out = scramble_off_reg;

    chk_irq_follows_flags: assert property (@(posedge clk_in) disable iff (rst)
        irq_out_low == !(|(flags[7:1] & mask_reg[7:1]))) // see R19
        else $error("interrupt does not match flags and mask");
    chk_read_clears_irq: assert property (@(posedge clk_in) disable iff (rst)
        rd_flags && events == 8'h00 |=> irq_out_low && flags == 8'h00) // see R02
        else $error("flag read did not clear");
    chk_read_returns_flags: assert property (@(posedge clk_in) disable iff (rst)
        rd_flags |=> reg_rdata_out == {8'h00, $past(flags)}) // see R02
        else $error("flag read returned wrong data");
    chk_masked_still_latch: assert property (@(posedge clk_in) disable iff (rst)
        events[5] && !mask_reg[5] |=> flags[5]) // see R04
        else $error("masked event not latched");
    chk_mask_reset_zero: assert property (@(posedge clk_in)
        $past(rst) |-> mask_reg == 8'h00 && irq_out_low) // see R05
        else $error("mask not zero after reset");
    chk_link_drop_flag: assert property (@(posedge clk_in) disable iff (rst)
        link_d_reg && !link_status_in |=> flags[4]) // see R09
        else $error("link drop not flagged");
    chk_energy_wake_irq: assert property (@(posedge clk_in) disable iff (rst)
        line_energy_present_in && !energy_d_reg && mask_reg[7] |=> !irq_out_low) // see R17
        else $error("energy wake did not interrupt");
    chk_coder_reset_on: assert property (@(posedge clk_in)
        $past(rst) |-> block_coder_on_out && !scramble_off_out
            && general_outputs_out == 3'h0) // see R14
        else $error("special control reset values wrong");
    chk_gpo_write: assert property (@(posedge clk_in) disable iff (rst)
        reg_wr_in && reg_addr_in == irq_ctrl_pkg::SPECIAL_ADDR
            |=> general_outputs_out == $past(reg_wdata_in[9:7])) // see R13
        else $error("gpo did not follow write");

    // each source latches its own flag bit
    chk_energy_latch: assert property (@(posedge clk_in) disable iff (rst) // see R07
        events[7]
        |=> flags[7])
        else $error("energy event not latched");

    chk_an_done_latch: assert property (@(posedge clk_in) disable iff (rst) // see R07
        autoneg_complete_in
        |=> flags[6])
        else $error("autoneg complete not latched");

    chk_rfault_latch: assert property (@(posedge clk_in) disable iff (rst) // see R07
        remote_fault_in
        |=> flags[5])
        else $error("remote fault not latched");

    chk_ack_latch: assert property (@(posedge clk_in) disable iff (rst) // see R08
        partner_ack_in
        |=> flags[3])
        else $error("partner ack not latched");

    chk_pd_fault_latch: assert property (@(posedge clk_in) disable iff (rst) // see R08
        parallel_detect_fault_in
        |=> flags[2])
        else $error("parallel detect fault not latched");

    chk_page_latch: assert property (@(posedge clk_in) disable iff (rst) // see R08
        page_received_in
        |=> flags[1])
        else $error("page received not latched");

    chk_flag0_zero: assert property (@(posedge clk_in) disable iff (rst) // see R19
        flags[0] == 1'b0)
        else $error("reserved flag bit set");

    // energy is an edge event, a steady level must not relatch
    chk_energy_level_quiet: assert property (@(posedge clk_in) disable iff (rst) // see R07
        line_energy_present_in && energy_d_reg && !flags[7]
        |=> !flags[7])
        else $error("steady energy relatched flag");

    chk_link_high_quiet: assert property (@(posedge clk_in) disable iff (rst) // see R09
        link_status_in && !flags[4]
        |=> !flags[4])
        else $error("link up set link down flag");

    chk_no_read_no_clear: assert property (@(posedge clk_in) disable iff (rst) // see R09
        !rd_flags
        |=> (flags & $past(flags)) == $past(flags))
        else $error("flag dropped without a read");

    chk_read_keeps_new: assert property (@(posedge clk_in) disable iff (rst) // see R02
        rd_flags && page_received_in
        |=> flags[1])
        else $error("event lost to a read clear");

    chk_rdata_holds: assert property (@(posedge clk_in) disable iff (rst) // see R02
        !reg_rd_in
        |=> $stable(reg_rdata_out))
        else $error("read data changed without a read");

    chk_mask_write: assert property (@(posedge clk_in) disable iff (rst) // see R03
        reg_wr_in && reg_addr_in == irq_ctrl_pkg::EN_MASK_ADDR
        |=> mask_reg == $past(reg_wdata_in[7:0]))
        else $error("mask did not follow write");

    chk_mask_hold: assert property (@(posedge clk_in) disable iff (rst) // see R03
        !(reg_wr_in && reg_addr_in == irq_ctrl_pkg::EN_MASK_ADDR)
        |=> $stable(mask_reg))
        else $error("mask changed without a write");

    chk_mask_upper_zero: assert property (@(posedge clk_in) disable iff (rst) // see R10
        reg_rd_in && reg_addr_in == irq_ctrl_pkg::EN_MASK_ADDR
        |=> reg_rdata_out[15:8] == 8'h00)
        else $error("mask upper byte not zero");

    chk_rsvd_reads_zero: assert property (@(posedge clk_in) disable iff (rst) // see R11
        reg_rd_in && reg_addr_in == irq_ctrl_pkg::TEST_RSVD_ADDR
        |=> reg_rdata_out == 16'h0000)
        else $error("testability block read not zero");

    chk_unmasked_irq: assert property (@(posedge clk_in) disable iff (rst) // see R01
        flags[4] && mask_reg[4]
        |-> !irq_out_low)
        else $error("enabled flag did not interrupt");

    chk_irq_needs_enable: assert property (@(posedge clk_in) disable iff (rst) // see R05
        !irq_out_low
        |-> |(mask_reg[7:1]))
        else $error("interrupt with every source masked");

    chk_autodone_view: assert property (@(posedge clk_in) disable iff (rst) // see R12
        reg_rd_in && reg_addr_in == irq_ctrl_pkg::SPECIAL_ADDR
        |=> reg_rdata_out[12] == $past(autoneg_done_in))
        else $error("autoneg done bit wrong");

    chk_speed_view: assert property (@(posedge clk_in) disable iff (rst) // see R15
        reg_rd_in && reg_addr_in == irq_ctrl_pkg::SPECIAL_ADDR
        |=> reg_rdata_out[4:2] == $past(resolved_speed_code_in))
        else $error("speed code field wrong");

    chk_coder_write: assert property (@(posedge clk_in) disable iff (rst) // see R14
        reg_wr_in && reg_addr_in == irq_ctrl_pkg::SPECIAL_ADDR
        |=> block_coder_on_out == $past(reg_wdata_in[6]))
        else $error("coder enable did not follow write");

    chk_scramble_write: assert property (@(posedge clk_in) disable iff (rst) // see R16
        reg_wr_in && reg_addr_in == irq_ctrl_pkg::SPECIAL_ADDR
        |=> scramble_off_out == $past(reg_wdata_in[0]))
        else $error("scramble disable did not follow write");

    chk_special_hold: assert property (@(posedge clk_in) disable iff (rst) // see R13
        !(reg_wr_in && reg_addr_in == irq_ctrl_pkg::SPECIAL_ADDR)
        |=> $stable(general_outputs_out) && $stable(block_coder_on_out))
        else $error("special control changed without a write");

    // reset checks carry no disable, they look at the reset itself
    chk_irq_reset_high: assert property (@(posedge clk_in) // see R05
        rst
        |=> irq_out_low)
        else $error("interrupt active after reset");

    chk_flags_reset_zero: assert property (@(posedge clk_in) // see R18
        rst
        |=> flags == 8'h00)
        else $error("flags not cleared by reset");

    chk_rdata_reset_zero: assert property (@(posedge clk_in) // see R18
        rst
        |=> reg_rdata_out == 16'h0000)
        else $error("read data not cleared by reset");

    chk_soft_reset_clears: assert property (@(posedge clk_in) // see R18
        soft_rst_in
        |=> mask_reg == 8'h00 && general_outputs_out == 3'h0)
        else $error("software reset did not clear registers");
endmodule
`default_nettype wire

/* test/mgmt_host_model.sv */
`timescale 1ns/10ps
`default_nettype none
module mgmt_host_model
(
    input wire logic clk_in,
    input wire logic [15:0] reg_rdata_in,
    output logic [4:0] reg_addr_out,
    output logic reg_wr_out,
    output logic reg_rd_out,
    output logic [15:0] reg_wdata_out
);
    initial
    begin
        reg_addr_out = 5'h00;
        reg_wr_out = 1'b0;
        reg_rd_out = 1'b0;
        reg_wdata_out = 16'h0000;
    end
    // one strobe cycle per access; data is inverted once released
    task automatic access(input logic wr, input logic [4:0] a, input logic [15:0] d,
        output logic [15:0] q);
        @(posedge clk_in);
        #2;
        reg_addr_out = a;
        reg_wdata_out = (a == irq_ctrl_pkg::EN_MASK_ADDR) ? {8'h00, d[7:0]} : d;
        reg_wr_out = wr && (a != irq_ctrl_pkg::TEST_RSVD_ADDR);
        reg_rd_out = !wr;
        @(posedge clk_in);
        #2;
        q = reg_rdata_in;
        reg_wr_out = 1'b0;
        reg_rd_out = 1'b0;
        reg_wdata_out = ~reg_wdata_out;
    endtask
endmodule
`default_nettype wire

/* test/phy_mgmt_irq_and_special_ctrl_tb.sv */
`timescale 1ns/10ps
`default_nettype none
module phy_mgmt_irq_and_special_ctrl_tb;
    logic clk_in = 1'b0;
    logic sys_rst_in = 1'b1;
    logic soft_rst_in = 1'b0;
    logic [7:1] ev = 7'h00;
    logic an_done = 1'b0;
    logic [2:0] speed = 3'h0;
    logic [4:0] addr;
    logic wr;
    logic rd;
    logic [15:0] wdata;
    logic [15:0] rdata;
    logic irq_low;
    logic [2:0] gpo;
    logic coder;
    logic scr;
    int n_mismatch = 0;
    int compares = 0;
    logic [2:0] codes [4];
    mgmt_host_model host (.clk_in(clk_in), .reg_rdata_in(rdata), .reg_addr_out(addr),
        .reg_wr_out(wr), .reg_rd_out(rd), .reg_wdata_out(wdata));
    phy_mgmt_irq_and_special_ctrl dut (.clk_in(clk_in), .sys_rst_in(sys_rst_in),
        .soft_rst_in(soft_rst_in), .reg_addr_in(addr), .reg_wr_in(wr), .reg_rd_in(rd),
        .reg_wdata_in(wdata), .reg_rdata_out(rdata), .line_energy_present_in(ev[7]),
        .autoneg_complete_in(ev[6]), .remote_fault_in(ev[5]), .link_status_in(~ev[4]),
        .partner_ack_in(ev[3]), .parallel_detect_fault_in(ev[2]), .page_received_in(ev[1]),
        .autoneg_done_in(an_done), .resolved_speed_code_in(speed), .irq_out_low(irq_low),
        .general_outputs_out(gpo), .block_coder_on_out(coder), .scramble_off_out(scr));
    initial
    begin
        forever #12.5 clk_in = ~clk_in;
    end
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        compares++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic rd_chk(input logic [4:0] a, input logic [15:0] exp);
        logic [15:0] q;
        host.access(1'b0, a, 16'h0000, q);
        chk(q, exp);
    endtask
    task automatic wr_reg(input logic [4:0] a, input logic [15:0] d);
        logic [15:0] q;
        host.access(1'b1, a, d, q);
    endtask
    task automatic pulse(input int i);
        @(posedge clk_in);
        #2;
        ev[i] = 1'b1;
        @(posedge clk_in);
        #2;
        ev[i] = 1'b0;
    endtask
    task automatic test_masked;
        for (int i = 1; i < 8; i++)
            pulse(i);
        chk({15'h0, irq_low}, 16'h0001);
        rd_chk(irq_ctrl_pkg::SRC_FLAGS_ADDR, 16'h00fe);
        rd_chk(irq_ctrl_pkg::SRC_FLAGS_ADDR, 16'h0000);
        $display("test masked done");
    endtask
    task automatic test_mask_each;
        int j;
        for (int i = 1; i < 8; i++)
        begin
            j = (i == 7) ? 1 : i + 1;
            wr_reg(irq_ctrl_pkg::EN_MASK_ADDR, 16'h0001 << i);
            rd_chk(irq_ctrl_pkg::EN_MASK_ADDR, 16'h0001 << i);
            pulse(j);
            chk({15'h0, irq_low}, 16'h0001);
            pulse(i);
            chk({15'h0, irq_low}, 16'h0000);
            rd_chk(irq_ctrl_pkg::SRC_FLAGS_ADDR, (16'h0001 << i) | (16'h0001 << j));
            chk({15'h0, irq_low}, 16'h0001);
        end
        $display("test mask each done");
    endtask
    task automatic test_special;
        wr_reg(irq_ctrl_pkg::SPECIAL_ADDR, 16'h0281);
        chk({11'h0, gpo, coder, scr}, 16'h0015);
        for (int k = 0; k < 4; k++)
        begin
            an_done = k[0];
            speed = codes[k];
            rd_chk(irq_ctrl_pkg::SPECIAL_ADDR, {3'h0, k[0], 7'h14, codes[k], 2'h1});
        end
        $display("test special done");
    endtask
    task automatic test_soft_reset;
        wr_reg(irq_ctrl_pkg::EN_MASK_ADDR, 16'h00ff);
        pulse(6);
        @(posedge clk_in);
        #2;
        soft_rst_in = 1'b1;
        @(posedge clk_in);
        #2;
        soft_rst_in = 1'b0;
        chk({15'h0, irq_low}, 16'h0001);
        rd_chk(irq_ctrl_pkg::EN_MASK_ADDR, 16'h0000);
        rd_chk(irq_ctrl_pkg::SRC_FLAGS_ADDR, 16'h0000);
        chk({11'h0, gpo, coder, scr}, 16'h0002);
        $display("test soft reset done");
    endtask
    task automatic summarize;
        $display("comparisons %0d mismatches %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    initial
    begin
        codes = '{irq_ctrl_pkg::SPEED_10_HALF, irq_ctrl_pkg::SPEED_10_FULL,
            irq_ctrl_pkg::SPEED_100_HALF, irq_ctrl_pkg::SPEED_100_FULL};
        repeat (10) @(posedge clk_in);
        #2;
        sys_rst_in = 1'b0;
        chk({10'h0, gpo, coder, scr, irq_low}, 16'h0005);
        rd_chk(irq_ctrl_pkg::EN_MASK_ADDR, 16'h0000);
        rd_chk(irq_ctrl_pkg::SPECIAL_ADDR, 16'h0040);
        $display("test reset done");
        test_masked();
        test_mask_each();
        test_special();
        test_soft_reset();
        summarize();
    end
    // whole run needs well under 1000 cycles
    initial
    begin
        repeat (20000) @(posedge clk_in);
        n_mismatch++;
        summarize();
    end
endmodule
`default_nettype wire
